// *** bench/atm_slave_model.sv ***
// behavioural slave: one wait state per transfer, plus a stall switch
`timescale 1ns/1ps
module atm_slave_model (
    input  wire logic              clock_in,      // bus clock
    input  wire logic              rstn_in,       // sync reset, low active
    input  wire logic              hsel_in,       // select from monitor
    input  wire atm_pkg::atm_req_t req_in,        // address phase from monitor
    input  wire logic              hready_in,     // ready seen by the slave
    input  wire logic              stall_in,      // holds ready low while high
    output logic                   hreadyout_out, // slave ready
    output logic                   hresp_out,     // slave response
    output logic [31:0]            hrdata_out     // slave read data
);
    logic        dph_q;   // data phase open
    logic        wait_q;  // one wait still owed
    logic [31:0] addr_q;  // address of the open phase
    logic [31:0] junk_q;  // moves every cycle, so stale data never looks valid
    // ------------------------------------------------------------
    // data phase tracking
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            dph_q  <= 1'b0;
            wait_q <= 1'b0;
            addr_q <= 32'h0;
            junk_q <= 32'h1234abcd;
        end else begin
            junk_q <= junk_q + 32'h9e3779b9;
            if (hready_in) begin // new phase only when the bus is ready
                dph_q  <= hsel_in && req_in.trans[1];
                wait_q <= 1'b1;
                addr_q <= req_in.addr;
            end else if (!stall_in) begin // a stall freezes the wait
                wait_q <= 1'b0;
            end
        end
    end
    assign hreadyout_out = !dph_q || !wait_q;
    assign hresp_out     = 1'b0; // this slave never errors itself
    assign hrdata_out    = (dph_q && !wait_q) ? ~addr_q : junk_q;
endmodule

// *** bench/atm_stall_monitor_bench.sv ***
// self-checking bench for the bus stall watchdog
`timescale 1ns/1ps
module atm_stall_monitor_bench;
    localparam int LIM = 2; // short limit keeps runs brief
    logic              clock_in, rstn_in, hsel, hready_s, rdy_s, resp_s, stall;
    logic              sel_m, rdy_m, rdy_sl, resp_sl, flag, resp, pre_resp, sel_seen;
    logic [1:0]        trans_seen;
    logic [31:0]       wd_s, rd_s, wd_m, rd_sl, rd;
    atm_pkg::atm_req_t req_s, req_m;
    int                error_cnt, checks, waits;
    atm_stall_monitor #(.timeout_cycle_limit(LIM)) u_atm_stall_monitor (
        .clock_in(clock_in), .rstn_in(rstn_in), .hsel_s_in(hsel), .req_s_in(req_s),
        .hready_s_in(hready_s), .hwdata_s_in(wd_s), .hreadyout_s_out(rdy_s),
        .hresp_s_out(resp_s), .hrdata_s_out(rd_s), .hsel_m_out(sel_m), .req_m_out(req_m),
        .hready_m_out(rdy_m), .hwdata_m_out(wd_m), .hreadyout_m_in(rdy_sl),
        .hresp_m_in(resp_sl), .hrdata_m_in(rd_sl), .stall_expired_flag_out(flag));
    atm_slave_model u_atm_slave_model (
        .clock_in(clock_in), .rstn_in(rstn_in), .hsel_in(sel_m), .req_in(req_m),
        .hready_in(rdy_m), .stall_in(stall), .hreadyout_out(rdy_sl),
        .hresp_out(resp_sl), .hrdata_out(rd_sl));
    assign hready_s = rdy_s; // single slave: global ready is its ready
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done;
        if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one transfer, started at a falling edge while the bus is ready
    task automatic xfer(input logic [1:0] tr, input logic [31:0] a);
        int n;
        hsel = 1'b1;
        req_s.trans = tr;
        req_s.addr = a;
        #1 sel_seen = sel_m;
        trans_seen = req_m.trans;
        @(negedge clock_in);
        hsel = 1'b0;
        req_s.trans = atm_pkg::TRANS_IDLE;
        waits = 0;
        pre_resp = 1'b0;
        for (n = 0; n < 200 && rdy_s !== 1'b1; n++) begin // bounded wait
            pre_resp = resp_s;
            waits++;
            @(negedge clock_in);
        end
        if (n == 200) begin
            error_cnt++;
            test_done();
        end
        resp = resp_s;
        rd = rd_s;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_pass;
        wd_s = 32'h5a5a0001;
        xfer(atm_pkg::TRANS_NONSEQ, 32'h100);
        chk("wdata", 32'h5a5a0001, wd_m);
        chk("resp", {31'h0, atm_pkg::RESP_OKAY}, {31'h0, resp});
        chk("rdata", ~32'h100, rd);
        chk("waits", 32'h1, waits);
        chk("sel", 32'h1, {31'h0, sel_seen});
        chk("trans", {30'h0, atm_pkg::TRANS_NONSEQ}, {30'h0, trans_seen});
    endtask
    task automatic t_stall;
        stall = 1'b1; // slave now hangs
        xfer(atm_pkg::TRANS_NONSEQ, 32'h200);
        chk("resp", 32'h1, {31'h0, resp});
        chk("waits", LIM + 2, waits);
        chk("err first", 32'h1, {31'h0, pre_resp});
        chk("flag", 32'h1, {31'h0, flag});
        // cut-off slave sees its own ready, so the hung transfer can still end
        chk("slave ready", 32'h0, {31'h0, rdy_m});
    endtask
    task automatic t_block;
        xfer(atm_pkg::TRANS_NONSEQ, 32'h300);
        chk("resp", 32'h1, {31'h0, resp});
        chk("waits", 32'h1, waits);
        chk("err first", 32'h1, {31'h0, pre_resp});
        chk("sel", 32'h0, {31'h0, sel_seen});
        chk("trans", {30'h0, atm_pkg::TRANS_IDLE}, {30'h0, trans_seen});
        chk("flag", 32'h1, {31'h0, flag});
    endtask
    task automatic t_release;
        stall = 1'b0;
        @(negedge clock_in);
        chk("flag", 32'h1, {31'h0, flag});
        @(negedge clock_in);
        chk("flag", 32'h0, {31'h0, flag});
        repeat (2) @(negedge clock_in);
        xfer(atm_pkg::TRANS_NONSEQ, 32'h400);
        chk("resp", 32'h0, {31'h0, resp});
        chk("rdata", ~32'h400, rd);
    endtask
    // stall inside a burst; slave recovers while beats still arrive
    task automatic t_burst;
        stall = 1'b1;
        req_s.burst = 3'h1;
        xfer(atm_pkg::TRANS_NONSEQ, 32'h500);
        chk("resp", 32'h1, {31'h0, resp});
        xfer(atm_pkg::TRANS_SEQ, 32'h504);
        chk("resp", 32'h1, {31'h0, resp});
        stall = 1'b0;
        xfer(atm_pkg::TRANS_SEQ, 32'h508);
        chk("resp", 32'h1, {31'h0, resp});
        chk("sel", 32'h0, {31'h0, sel_seen});
        // slave is done now, but a paused burst must still be swallowed
        hsel = 1'b1;
        req_s.trans = atm_pkg::TRANS_BUSY;
        repeat (2) @(negedge clock_in);
        chk("busy ready", 32'h1, {31'h0, rdy_s});
        chk("busy resp", 32'h0, {31'h0, resp_s});
        chk("busy sel", 32'h0, {31'h0, sel_m});
        xfer(atm_pkg::TRANS_SEQ, 32'h50c);
        chk("resp", 32'h1, {31'h0, resp});
        chk("waits", 32'h1, waits);
        repeat (3) @(negedge clock_in);
        chk("flag", 32'h0, {31'h0, flag});
        xfer(atm_pkg::TRANS_NONSEQ, 32'h600);
        chk("resp", 32'h0, {31'h0, resp});
        chk("rdata", ~32'h600, rd);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        error_cnt = 0;
        checks = 0;
        rstn_in = 1'b0;
        hsel = 1'b0;
        stall = 1'b0;
        wd_s = 32'h0;
        req_s = '0;
        repeat (6) @(negedge clock_in);
        rstn_in = 1'b1;
        @(negedge clock_in);
        t_pass();
        t_stall();
        t_block();
        t_release();
        t_burst();
        test_done();
    end
endmodule

// *** rtl/atm_pkg.sv ***
// shared types and constants for the bus stall watchdog
package atm_pkg;

    // ------------------------------------------------------------
    // bus encodings
    // ------------------------------------------------------------
    localparam logic [1:0] TRANS_IDLE   = 2'h0;  // no transfer
    localparam logic [1:0] TRANS_BUSY   = 2'h1;  // burst pause
    localparam logic [1:0] TRANS_NONSEQ = 2'h2;  // first beat or single
    localparam logic [1:0] TRANS_SEQ    = 2'h3;  // later burst beat
    localparam logic       RESP_OKAY    = 1'b0;  // good answer
    localparam logic       RESP_ERROR   = 1'b1;  // error answer

    // ------------------------------------------------------------
    // stall limit: default and legal range
    // ------------------------------------------------------------
    localparam int LIMIT_DEFAULT = 16;           // wait cycles before expiry
    localparam int LIMIT_MIN     = 2;            // smallest legal limit
    localparam int LIMIT_MAX     = 1024;         // largest legal limit
    localparam int COUNT_W       = 11;           // holds 0..LIMIT_MAX

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [COUNT_W-1:0] COUNT_RST = 11'h000;  // counter at reset
    localparam logic               FLAG_RST  = 1'b0;     // flag at reset
    localparam logic               DPH_RST   = 1'b0;     // no data phase

    // address-phase bundle, same on both sides
    typedef struct packed {
        logic [31:0] addr;      // transfer address
        logic [1:0]  trans;     // transfer type
        logic        write;     // 1 for write
        logic [2:0]  size;      // transfer size
        logic [2:0]  burst;     // burst kind
        logic [3:0]  prot;      // protection bits
        logic        mastlock;  // locked sequence
    } atm_req_t;

    // watchdog states
    typedef enum logic [1:0] {
        ST_PASS,    // transparent
        ST_ERR1,    // error, first cycle (not ready)
        ST_ERR2,    // error, second cycle (ready)
        ST_BLOCK    // slave cut off, idle answers okay
    } atm_state_t;

endpackage

// *** rtl/atm_stall_monitor.sv ***
// inline stall watchdog between bus masters and one slave
`timescale 1ns/1ps
// Contract
// [RULE1] sits before one slave, transparent when healthy
// [RULE2] count slave waits, error after limit exceeded
// [RULE3] after expiry, further accesses errored, not forwarded
// [RULE4] unblock once slave completes the stalled transfer
// [RULE5] mask remaining burst beats before going transparent
// [RULE6] build-time limit, legal 2 to 1024, default 16
// [RULE7] expiry flag high until slave ready returns
// [RULE8] error takes two cycles: wait, then ready
module atm_stall_monitor #(
    parameter int timeout_cycle_limit = atm_pkg::LIMIT_DEFAULT  // wait cycles tolerated
) (
    input  wire logic             clock_in,               // bus clock, 25 MHz
    input  wire logic             rstn_in,                // synchronous reset, low active
    // master side
    input  wire logic             hsel_s_in,              // slave selected
    input  wire atm_pkg::atm_req_t req_s_in,              // address phase from master
    input  wire logic             hready_s_in,            // bus ready seen by all
    input  wire logic [31:0]      hwdata_s_in,            // write data
    output logic                  hreadyout_s_out,        // ready toward master
    output logic                  hresp_s_out,            // response toward master
    output logic [31:0]           hrdata_s_out,           // read data toward master
    // slave side
    output logic                  hsel_m_out,             // select to slave
    output atm_pkg::atm_req_t     req_m_out,              // address phase to slave
    output logic                  hready_m_out,           // ready input of slave
    output logic [31:0]           hwdata_m_out,           // write data to slave
    input  wire logic             hreadyout_m_in,         // slave ready
    input  wire logic             hresp_m_in,             // slave response
    input  wire logic [31:0]      hrdata_m_in,            // slave read data
    // event
    output logic                  stall_expired_flag_out  // stall detected, slave not done
);

    // ------------------------------------------------------------
    // limit as counter value
    // ------------------------------------------------------------
    localparam logic [atm_pkg::COUNT_W-1:0] LIMIT_CNT =
        atm_pkg::COUNT_W'(timeout_cycle_limit);  // [RULE6]

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    atm_pkg::atm_state_t          state_q, state_d;  // watchdog state
    logic [atm_pkg::COUNT_W-1:0]  count_q, count_d;  // wait cycle count
    logic                         dph_q, dph_d;      // slave transfer in data phase
    logic                         flag_q, flag_d;    // expiry seen, slave still stalled

    logic access_in;  // active address phase taken this cycle
    logic cont_in;    // master continuing a burst
    logic stall_hit;  // wait count went past the limit

    // true when an address phase carries a real transfer
    function automatic logic is_active(input logic [1:0] trans);
        is_active = trans[1];
    endfunction

    // ------------------------------------------------------------
    // decode of the master's address phase
    // ------------------------------------------------------------
    always_comb begin
        access_in = hsel_s_in && hready_s_in && is_active(req_s_in.trans);
        // busy or seq means the burst is still running
        cont_in   = hsel_s_in && (req_s_in.trans == atm_pkg::TRANS_SEQ ||
                                  req_s_in.trans == atm_pkg::TRANS_BUSY);
        // more than limit wait cycles: this is the one past the limit
        stall_hit = (state_q == atm_pkg::ST_PASS) && dph_q && !hreadyout_m_in &&
                    (count_q == LIMIT_CNT);  // [RULE2]
    end

    // ------------------------------------------------------------
    // next state, counter and flag
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        dph_d   = dph_q;
        flag_d  = flag_q;
        case (state_q)
            atm_pkg::ST_PASS: begin
                if (stall_hit) begin
                    state_d = atm_pkg::ST_ERR1;  // [RULE2]
                    count_d = atm_pkg::COUNT_RST;
                    dph_d   = 1'b0;
                end else if (dph_q && !hreadyout_m_in) begin
                    count_d = count_q + 11'h001;  // one more wait cycle
                end else begin
                    count_d = atm_pkg::COUNT_RST;
                end
                // track data phase only while the bus advances
                if (!stall_hit && hready_s_in) begin
                    dph_d = hsel_s_in && is_active(req_s_in.trans);
                end
            end
            atm_pkg::ST_ERR1: begin
                state_d = atm_pkg::ST_ERR2;  // [RULE8]
            end
            atm_pkg::ST_ERR2, atm_pkg::ST_BLOCK: begin
                if (access_in) begin
                    state_d = atm_pkg::ST_ERR1;  // [RULE3] [RULE5]
                end else if (!flag_q && !cont_in) begin
                    // slave done and no burst beats left to swallow
                    state_d = atm_pkg::ST_PASS;  // [RULE4] [RULE5]
                end else begin
                    state_d = atm_pkg::ST_BLOCK;
                end
            end
            default: begin
                state_d = atm_pkg::ST_PASS;
            end
        endcase
        // flag rises on expiry, falls when the slave finally answers
        if (stall_hit) begin
            flag_d = 1'b1;  // [RULE7]
        end else if (hreadyout_m_in) begin
            flag_d = 1'b0;  // [RULE7]
        end
    end

    // register stage, synchronous reset
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            state_q <= atm_pkg::ST_PASS;
            count_q <= atm_pkg::COUNT_RST;
            dph_q   <= atm_pkg::DPH_RST;
            flag_q  <= atm_pkg::FLAG_RST;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            dph_q   <= dph_d;
            flag_q  <= flag_d;
        end
    end

    // ------------------------------------------------------------
    // path muxing: transparent or cut off
    // ------------------------------------------------------------
    always_comb begin
        hsel_m_out   = hsel_s_in;
        req_m_out    = req_s_in;
        hwdata_m_out = hwdata_s_in;
        hrdata_s_out = hrdata_m_in;
        case (state_q)
            atm_pkg::ST_PASS: begin
                hready_m_out    = hready_s_in;     // [RULE1]
                hreadyout_s_out = hreadyout_m_in;  // [RULE1]
                hresp_s_out     = hresp_m_in;      // [RULE1]
            end
            atm_pkg::ST_ERR1: begin
                hready_m_out    = hreadyout_m_in;
                hreadyout_s_out = 1'b0;            // [RULE8]
                hresp_s_out     = atm_pkg::RESP_ERROR;
            end
            atm_pkg::ST_ERR2: begin
                hready_m_out    = hreadyout_m_in;
                hreadyout_s_out = 1'b1;            // [RULE8]
                hresp_s_out     = atm_pkg::RESP_ERROR;
            end
            default: begin
                hready_m_out    = hreadyout_m_in;
                hreadyout_s_out = 1'b1;
                hresp_s_out     = atm_pkg::RESP_OKAY;
            end
        endcase
        // while cut off the slave only sees idle, and its own ready so
        // that the stalled transfer can still finish on its side
        if (state_q != atm_pkg::ST_PASS) begin
            hsel_m_out      = 1'b0;                  // [RULE3]
            req_m_out.trans = atm_pkg::TRANS_IDLE;   // [RULE3] [RULE5]
        end
        stall_expired_flag_out = flag_q;             // [RULE7]
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_limit_legal: assert property (@(posedge clock_in) disable iff (!rstn_in) // [RULE6]
        timeout_cycle_limit >= atm_pkg::LIMIT_MIN && timeout_cycle_limit <= atm_pkg::LIMIT_MAX)
        else $error("stall limit outside legal range");

    chk_pass_transparent: assert property (@(posedge clock_in) disable iff (!rstn_in) // [RULE1]
        state_q == atm_pkg::ST_PASS |->
            req_m_out == req_s_in && hreadyout_s_out == hreadyout_m_in &&
            hresp_s_out == hresp_m_in)
        else $error("transparent path altered");

    chk_count_bound: assert property (@(posedge clock_in) disable iff (!rstn_in) // [RULE2]
        count_q <= LIMIT_CNT)
        else $error("wait count ran past the limit");

    chk_expiry_error: assert property (@(posedge clock_in) disable iff (!rstn_in) // [RULE2]
        (state_q == atm_pkg::ST_PASS && dph_q && !hreadyout_m_in && count_q == LIMIT_CNT) |=>
            (!hreadyout_s_out && hresp_s_out) ##1 (hreadyout_s_out && hresp_s_out))
        else $error("expired stall not answered with error");

    chk_block_masks: assert property (@(posedge clock_in) disable iff (!rstn_in) // [RULE3]
        state_q != atm_pkg::ST_PASS |-> !hsel_m_out &&
            req_m_out.trans == atm_pkg::TRANS_IDLE)
        else $error("access leaked to slave while blocked");

    chk_access_errored: assert property (@(posedge clock_in) disable iff (!rstn_in) // [RULE3]
        (state_q inside {atm_pkg::ST_ERR2, atm_pkg::ST_BLOCK} && access_in) |=>
            !hreadyout_s_out && hresp_s_out)
        else $error("blocked access not errored");

    chk_unblock: assert property (@(posedge clock_in) disable iff (!rstn_in) // [RULE4]
        (state_q == atm_pkg::ST_BLOCK && !flag_q && !hsel_s_in) |=>
            state_q == atm_pkg::ST_PASS)
        else $error("monitor did not become transparent");

    chk_burst_drain: assert property (@(posedge clock_in) disable iff (!rstn_in) // [RULE5]
        (state_q != atm_pkg::ST_PASS && hsel_s_in &&
         req_s_in.trans == atm_pkg::TRANS_BUSY) |=> state_q != atm_pkg::ST_PASS)
        else $error("went transparent inside a burst");

    chk_flag_holds: assert property (@(posedge clock_in) disable iff (!rstn_in) // [RULE7]
        (stall_expired_flag_out && !hreadyout_m_in) |=> stall_expired_flag_out)
        else $error("expiry flag dropped before slave ready");

    chk_flag_clears: assert property (@(posedge clock_in) disable iff (!rstn_in) // [RULE7]
        $fell(stall_expired_flag_out) |-> $past(hreadyout_m_in))
        else $error("expiry flag fell without slave ready");

    chk_err_pair: assert property (@(posedge clock_in) disable iff (!rstn_in) // [RULE8]
        (hresp_s_out && !hreadyout_s_out && state_q != atm_pkg::ST_PASS) |=>
            hresp_s_out && hreadyout_s_out)
        else $error("error answer not two cycles");

endmodule
